// *** hw/fault_flag_mem.v ***
// per-channel sticky fault flags, read back through a register
// assumes one clock domain and a synchronous clear
`timescale 1ns/1ps
module fault_flag_mem #(
   parameter N = 4
) (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // set and clear
   input wire [N-1:0] set_bits,
   input wire clr_all,
   // read data
   output reg [N-1:0] rd_data
);
   reg [N-1:0] flag_r;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flag_r <= {N{1'b0}};
         rd_data <= {N{1'b0}};
      end else begin
         flag_r <= (clr_all ? {N{1'b0}} : flag_r) | set_bits;
         rd_data <= (clr_all ? {N{1'b0}} : flag_r) | set_bits;
      end
   end
endmodule // fault_flag_mem

// *** hw/power_stage_ctrl.v ***
// protection and reset control for a four half-bridge power stage
// assumes pwm, fault sensor and reset inputs are synchronous to clk_sys
// How it works
// - long cycle limiting latches channel overload shutdown
// - latched overcurrent mode shuts channel until reset
// - cycle limiting flips output, unreported, self-clears
// - missing pwm sets channels hi-z, self-clears
// - reset low forces all outputs hi-z
// - reset low pulls down except single-ended
// - reset low forces shutdown report high
// - reset rise runs startup then switching
// - near_saturation_flag flag when output pulses are skipped
// - outputs invert input polarity
// - thermal shutdown latched until reset
// - shutdown and thermal warning reported low
`timescale 1ns/1ps
`include "power_stage_regs.vh"
module power_stage_ctrl #(
   parameter CH = 4,
   parameter OVERLOAD_CYCLES = `OVERLOAD_CYCLES,
   parameter STUCK_CYCLES = `STUCK_CYCLES,
   parameter STARTUP_CYCLES = `STARTUP_CYCLES
) (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // device pins from the controller
   input wire reset_pin_n,
   input wire [CH-1:0] pwm_in,
   // analog sensor levels
   input wire over_temp_shutdown,
   input wire temp_warn,
   input wire [CH-1:0] over_current,
   input wire [CH-1:0] loop_saturated,
   // half-bridge drive
   output reg [CH-1:0] gate_high,
   output reg [CH-1:0] gate_low,
   output reg [CH-1:0] weak_pulldown,
   // status pins, shutdown and thermal warning open drain
   output reg fault_n_o,
   output reg fault_n_oe,
   output reg thermal_warning_n_o,
   output reg thermal_warning_n_oe,
   output reg near_saturation_flag,
   output reg irq,
   // avalon-mm slave
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest
);
   // ------------------------------------------------------------
   // reset pin synchroniser
   // ------------------------------------------------------------
   reg rst_s1_r, rst_s2_r, rst_s3_r;
   wire rst_rise = rst_s2_r & ~rst_s3_r;
   wire rst_low = ~rst_s2_r;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
         rst_s3_r <= 1'b0;
      end else begin
         rst_s1_r <= reset_pin_n;
         rst_s2_r <= rst_s1_r;
         rst_s3_r <= rst_s2_r;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg [2:0] ctrl_r;
   reg [`IRQ_WIDTH-1:0] irq_stat_r, irq_mask_r;
   wire [1:0] mode = ctrl_r[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
   wire latch_oc = ctrl_r[`CTRL_LATCH_OC];

   // ------------------------------------------------------------
   // startup sequencer
   // ------------------------------------------------------------
   localparam ST_HOLD = 2'h0;
   localparam ST_START = 2'h1;
   localparam ST_RUN = 2'h2;
   reg [1:0] state_r;
   reg [15:0] start_cnt_r;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_HOLD;
         start_cnt_r <= 16'h0000;
      end else if (rst_low) begin
         state_r <= ST_HOLD;
         start_cnt_r <= 16'h0000;
      end else begin
         case (state_r)
            ST_HOLD: begin
               if (rst_rise) begin
                  state_r <= ST_START;
                  start_cnt_r <= 16'h0000;
               end
            end
            ST_START: begin
               if (start_cnt_r == STARTUP_CYCLES - 1)
                  state_r <= ST_RUN;
               else
                  start_cnt_r <= start_cnt_r + 16'h0001;
            end
            ST_RUN: state_r <= ST_RUN;
            default: state_r <= ST_HOLD;
         endcase
      end
   end
   wire running = (state_r == ST_RUN);

   // ------------------------------------------------------------
   // thermal shutdown latch
   // ------------------------------------------------------------
   reg thermal_lat_r;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         thermal_lat_r <= 1'b0;
      else if (over_temp_shutdown)
         thermal_lat_r <= 1'b1;
      else if (rst_low)
         thermal_lat_r <= 1'b0;
   end

   // ------------------------------------------------------------
   // per-channel overcurrent and stuck pwm
   // ------------------------------------------------------------
   reg [CH-1:0] oc_lat_r, stuck_r, pwm_d_r, flip_r;
   wire [CH-1:0] oc_lat_set;
   wire [CH-1:0] oc_flags;
   genvar g;
   generate
      for (g = 0; g < CH; g = g + 1) begin : chan
         reg [15:0] cbc_cnt_r;
         reg [15:0] idle_cnt_r;
         assign oc_lat_set[g] = running & over_current[g] &
                                (latch_oc | cbc_cnt_r == OVERLOAD_CYCLES - 1);
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               cbc_cnt_r <= 16'h0000;
               idle_cnt_r <= 16'h0000;
               oc_lat_r[g] <= 1'b0;
               stuck_r[g] <= 1'b0;
               pwm_d_r[g] <= 1'b0;
               flip_r[g] <= 1'b0;
            end else begin
               pwm_d_r[g] <= pwm_in[g];
               if (oc_lat_set[g])
                  oc_lat_r[g] <= 1'b1;
               else if (rst_low)
                  oc_lat_r[g] <= 1'b0;
               if (running & over_current[g] & ~latch_oc) begin
                  if (cbc_cnt_r != OVERLOAD_CYCLES - 1)
                     cbc_cnt_r <= cbc_cnt_r + 16'h0001;
                  if (pwm_in[g] != pwm_d_r[g])
                     flip_r[g] <= ~flip_r[g];
               end else begin
                  cbc_cnt_r <= 16'h0000;
                  flip_r[g] <= 1'b0;
               end
               if (pwm_in[g] != pwm_d_r[g]) begin
                  idle_cnt_r <= 16'h0000;
                  stuck_r[g] <= 1'b0;
               end else if (idle_cnt_r == STUCK_CYCLES - 1)
                  stuck_r[g] <= 1'b1;
               else
                  idle_cnt_r <= idle_cnt_r + 16'h0001;
            end
         end
      end
   endgenerate

   fault_flag_mem #(.N(CH)) u_oc_flags (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .set_bits(oc_lat_set),
      .clr_all(rst_rise),
      .rd_data(oc_flags)
   );

   // ------------------------------------------------------------
   // output drive
   // ------------------------------------------------------------
   wire all_stuck = &stuck_r;
   wire [CH-1:0] ch_off = oc_lat_r | stuck_r | {CH{all_stuck | thermal_lat_r}};
   wire [CH-1:0] drive = ~pwm_in ^ flip_r;
   wire any_shutdown = thermal_lat_r | (|oc_lat_r);

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gate_high <= {CH{1'b0}};
         gate_low <= {CH{1'b0}};
         weak_pulldown <= {CH{1'b0}};
         fault_n_o <= 1'b0;
         fault_n_oe <= 1'b0;
         thermal_warning_n_o <= 1'b0;
         thermal_warning_n_oe <= 1'b0;
         near_saturation_flag <= 1'b0;
      end else begin
         if (rst_low | ~running) begin
            gate_high <= {CH{1'b0}};
            gate_low <= {CH{1'b0}};
         end else begin
            gate_high <= drive & ~ch_off;
            gate_low <= ~drive & ~ch_off;
         end
         weak_pulldown <= {CH{rst_low & (mode != `MODE_SE)}};
         fault_n_o <= 1'b0;
         fault_n_oe <= ~rst_low & any_shutdown;
         thermal_warning_n_o <= 1'b0;
         thermal_warning_n_oe <= temp_warn | thermal_lat_r;
         near_saturation_flag <= running & (|(loop_saturated & ~ch_off));
      end
   end

   // ------------------------------------------------------------
   // interrupts and avalon-mm slave
   // ------------------------------------------------------------
   wire [`IRQ_WIDTH-1:0] events = {temp_warn, near_saturation_flag, |stuck_r, |oc_lat_set, over_temp_shutdown};
   // a write lands at the edge where the master sees waitrequest low
   wire wr_hit = write & ~waitrequest;
   wire [`IRQ_WIDTH-1:0] w1c = (wr_hit && address == `REG_IRQ_STAT) ? writedata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `CTRL_RESET_VAL;
         irq_stat_r <= {`IRQ_WIDTH{1'b0}};
         irq_mask_r <= {`IRQ_WIDTH{1'b0}};
         readdata <= 32'h00000000;
         waitrequest <= 1'b1;
         irq <= 1'b0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~w1c) | events;
         irq <= |(irq_stat_r & irq_mask_r);
         waitrequest <= ~((read | write) & waitrequest);
         if (wr_hit && address == `REG_CTRL)
            ctrl_r <= writedata[2:0];
         if (wr_hit && address == `REG_IRQ_MASK)
            irq_mask_r <= writedata[`IRQ_WIDTH-1:0];
         if (read & waitrequest) begin
            case (address)
               `REG_CTRL: readdata <= {29'h0, ctrl_r};
               `REG_STATUS: readdata <= {16'h0, 4'h0, stuck_r, oc_flags, thermal_lat_r, state_r, rst_s2_r};
               `REG_IRQ_STAT: readdata <= {27'h0, irq_stat_r};
               `REG_IRQ_MASK: readdata <= {27'h0, irq_mask_r};
               default: readdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // power_stage_ctrl

// *** hw/power_stage_regs.vh ***
// constants for the power stage protection and reset control block
// assumes a 10 MHz system clock
`ifndef POWER_STAGE_REGS_VH
`define POWER_STAGE_REGS_VH

// register byte offsets on the avalon-mm slave
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_IRQ_STAT 4'h8
`define REG_IRQ_MASK 4'hc

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_LATCH_OC 2
`define CTRL_RESET_VAL 3'h0

// output configuration modes
`define MODE_BTL 2'h0
`define MODE_PARALLEL_BRIDGE_MODE 2'h1
`define MODE_SE 2'h2

// interrupt status bits
`define IRQ_THERMAL 0
`define IRQ_OVERLOAD 1
`define IRQ_STUCK 2
`define IRQ_NEAR_SATURATION_FLAG 3
`define IRQ_WARN 4
`define IRQ_WIDTH 5

// timing
`define CLK_HZ 10000000
`define OVERLOAD_US 2600
`define OVERLOAD_CYCLES ((`OVERLOAD_US * (`CLK_HZ / 1000000)))
`define STUCK_CYCLES 2000
`define STARTUP_CYCLES 1000

`endif

// *** testbench/power_stage_ctrl_properties.sv ***
// checker for the power stage protection block, sees only its ports
// assumes the reset pin is synchronised by two flops inside the block
`timescale 1ns/1ps
module power_stage_ctrl_properties #(
   parameter CH = 4
) (
   input wire clk_sys,
   input wire rst_n,
   input wire reset_pin_n,
   input wire over_temp_shutdown,
   input wire temp_warn,
   input wire [CH-1:0] loop_saturated,
   input wire [CH-1:0] gate_high,
   input wire [CH-1:0] gate_low,
   input wire fault_n_o,
   input wire fault_n_oe,
   input wire thermal_warning_n_oe,
   input wire near_saturation_flag,
   input wire read,
   input wire write,
   input wire waitrequest
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_reset_hiz: assert property ((!reset_pin_n)[*4] |-> gate_high == '0 && gate_low == '0)
      else $error("gates active while reset pin low");
   a_reset_quiet: assert property ((!reset_pin_n)[*4] |-> !fault_n_oe)
      else $error("shutdown report low while reset pin low");
   a_fault_low: assert property (fault_n_oe |-> !fault_n_o)
      else $error("shutdown report enabled but not low");
   a_fault_held: assert property (reset_pin_n && $past(reset_pin_n) && $past(reset_pin_n, 2)
      && $past(reset_pin_n, 3) && fault_n_oe |=> fault_n_oe) else $error("latched fault released without reset");
   a_thermal_hiz: assert property (over_temp_shutdown[*4] |-> gate_high == '0 && gate_low == '0)
      else $error("gates active during thermal shutdown");
   a_warn_report: assert property (temp_warn[*3] |-> thermal_warning_n_oe)
      else $error("thermal warning not reported");
   a_near_saturation_flag_quiet: assert property ((loop_saturated == '0)[*4] |-> !near_saturation_flag)
      else $error("near_saturation_flag flag without saturation");
   a_startup_hold: assert property ($rose(reset_pin_n) |-> (gate_high == '0 && gate_low == '0)[*5])
      else $error("switching before startup");
   a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus request not answered next cycle");
   a_bus_single: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   c_fault: cover property ($rose(fault_n_oe));
   c_warn: cover property ($rose(thermal_warning_n_oe));
   c_near_saturation_flag: cover property ($rose(near_saturation_flag));
   c_write: cover property (write && !waitrequest);
endmodule // power_stage_ctrl_properties

bind power_stage_ctrl power_stage_ctrl_properties #(.CH(CH)) u_props (.clk_sys(clk_sys), .rst_n(rst_n),
   .reset_pin_n(reset_pin_n), .over_temp_shutdown(over_temp_shutdown), .temp_warn(temp_warn),
   .loop_saturated(loop_saturated), .gate_high(gate_high), .gate_low(gate_low), .fault_n_o(fault_n_o),
   .fault_n_oe(fault_n_oe), .thermal_warning_n_oe(thermal_warning_n_oe),
   .near_saturation_flag(near_saturation_flag), .read(read), .write(write), .waitrequest(waitrequest));

// *** testbench/pwm_modulator.sv ***
// pwm modulator model: equal frames on every channel, duty set by the bench
// assumes one clock; run low freezes the lines, which is a stuck input
`timescale 1ns/1ps
module pwm_modulator #(
   parameter CH = 4,
   parameter FRAME = 16
) (
   // clock and control
   input wire clk_sys,
   input wire run,
   input wire [3:0] duty,
   // pwm lines
   output logic [CH-1:0] pwm_in
);
   int cnt = 0;
   initial pwm_in = '0;
   always @(posedge clk_sys) begin
      if (run) begin
         cnt <= (cnt + 1) % FRAME;
         pwm_in <= (cnt < duty) ? '1 : '0;
      end
   end
endmodule // pwm_modulator

// *** testbench/tb_power_stage_ctrl.sv ***
// self-checking bench for the power stage protection block
// assumes shortened startup, stuck and overload counts
`timescale 1ns/1ps
`include "power_stage_regs.vh"
module tb_power_stage_ctrl;
   localparam int STARTUP = 20, OVERLOAD = 50, STUCK = 20, COOL = 40;
   logic clk_sys = 0, rst_n = 0, reset_pin_n = 0, over_temp_shutdown = 0, temp_warn = 0, read = 0, write = 0;
   logic run = 1;
   logic [3:0] over_current = '0, loop_saturated = '0, address = '0, duty = 4'h8, oc;
   logic [31:0] writedata = '0, q;
   wire [3:0] pwm_in, gate_high, gate_low, weak_pulldown;
   wire fault_n_o, fault_n_oe, thermal_warning_n_o, thermal_warning_n_oe, near_saturation_flag, irq, waitrequest;
   wire [31:0] readdata;
   int failures = 0, total_checks = 0, seed = 25;
   pwm_modulator u_mod (.clk_sys(clk_sys), .run(run), .duty(duty), .pwm_in(pwm_in));
   power_stage_ctrl #(.OVERLOAD_CYCLES(OVERLOAD), .STUCK_CYCLES(STUCK), .STARTUP_CYCLES(STARTUP)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .pwm_in(pwm_in),
      .over_temp_shutdown(over_temp_shutdown), .temp_warn(temp_warn), .over_current(over_current),
      .loop_saturated(loop_saturated), .gate_high(gate_high), .gate_low(gate_low), .weak_pulldown(weak_pulldown),
      .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .thermal_warning_n_o(thermal_warning_n_o),
      .thermal_warning_n_oe(thermal_warning_n_oe), .near_saturation_flag(near_saturation_flag), .irq(irq),
      .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest));
   initial forever #50 clk_sys = ~clk_sys;
   function automatic logic [7:0] drive(input logic [3:0] p);
      return {~p, p};
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do @(posedge clk_sys); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 0;
      write <= 0;
   endtask
   task automatic pol();
      logic [3:0] p;
      duty <= 4'h6 + 4'($random(seed) & 3);
      p = pwm_in;
      do @(posedge clk_sys); while (pwm_in === p);
      cyc(3);
      chk("polarity", {gate_high, gate_low}, drive(pwm_in));
   endtask
   task automatic pin_cycle(input logic [3:0] pd);
      reset_pin_n <= 0;
      cyc(COOL);
      chk("report in reset", fault_n_oe, 0);
      chk("gates in reset", {gate_high, gate_low}, 0);
      chk("pulldown", weak_pulldown, pd);
      reset_pin_n <= 1;
      cyc(STARTUP + 12);
      chk("report after reset", fault_n_oe, 0);
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      cyc(20000);
      failures++;
      finish_test();
   end
   initial begin
      cyc(6);
      rst_n <= 1;
      bus(0, `REG_CTRL, 0);
      chk("ctrl reset", q, `CTRL_RESET_VAL);
      bus(0, 4'h2, 0);
      chk("unmapped", q, 0);
      bus(1, `REG_IRQ_MASK, 32'h1f);
      bus(0, `REG_IRQ_MASK, 0);
      chk("mask", q, 32'h1f);
      bus(1, `REG_CTRL, 32'h2);
      pin_cycle(4'h0);
      bus(1, `REG_CTRL, 32'h0);
      pin_cycle(4'hf);
      repeat (6) pol();
      loop_saturated <= 4'h1 << ($random(seed) & 3);
      cyc(4);
      chk("near_saturation_flag", near_saturation_flag, 1);
      loop_saturated <= '0;
      run <= 0;
      cyc(STUCK + 10);
      chk("stuck gates", {gate_high, gate_low}, 0);
      chk("stuck report", fault_n_oe, 0);
      run <= 1;
      cyc(STUCK);
      pol();
      oc = 4'h1 << ($random(seed) & 3);
      over_current <= oc;
      cyc(OVERLOAD - 15);
      chk("limit unreported", fault_n_oe, 0);
      cyc(30);
      chk("overload", fault_n_oe, 1);
      chk("report level", fault_n_o, 0);
      chk("overload hi-z", (gate_high | gate_low) & oc, 0);
      over_current <= '0;
      bus(0, `REG_IRQ_STAT, 0);
      chk("events", q, 32'h0e);
      chk("irq", irq, 1);
      bus(1, `REG_IRQ_MASK, 0);
      cyc(3);
      chk("masked", irq, 0);
      bus(1, `REG_IRQ_MASK, 32'h1f);
      pin_cycle(4'hf);
      bus(1, `REG_IRQ_STAT, 32'h1f);
      cyc(3);
      chk("cleared", irq, 0);
      bus(1, `REG_CTRL, 32'h4);
      over_current <= oc;
      cyc(3);
      over_current <= '0;
      cyc(25);
      chk("latched oc", fault_n_oe, 1);
      bus(0, `REG_STATUS, 0);
      chk("status", q, {oc, 4'h5});
      pin_cycle(4'hf);
      temp_warn <= 1;
      cyc(4);
      chk("warning", thermal_warning_n_oe, 1);
      chk("warning level", thermal_warning_n_o, 0);
      over_temp_shutdown <= 1;
      cyc(4);
      chk("thermal gates", {gate_high, gate_low}, 0);
      over_temp_shutdown <= 0;
      temp_warn <= 0;
      cyc(20);
      chk("thermal held", fault_n_oe, 1);
      pin_cycle(4'hf);
      pol();
      finish_test();
   end
endmodule // tb_power_stage_ctrl
